// ===== timer_one_defines.svh
// Register offsets, field positions, reset values and timing counts for the timer block
// Functional notes
// - Control bits 5 to 4 hold the input prescale select field that divides the selected input clock.
// - Prescale select 11 advances the counter once per eight input ticks.
// - Prescale select 10 advances the counter once per four input ticks.
// - Prescale select 01 advances the counter once per two input ticks.
// - Prescale select 00 advances the counter on every input tick.
// - The control register is eight bits, zero after reset; bits 7 to 2 and bit 0 are read/write, and bit 1 is not stored and reads zero.
// - The 16-bit counter rolls from all ones to zero and sets the rollover flag on the same edge.
`ifndef TIMER_ONE_DEFINES_SVH
`define TIMER_ONE_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TMR_CTRL_ADDR   2'h0
`define TMR_CNT_LO_ADDR 2'h1
`define TMR_CNT_HI_ADDR 2'h2
`define TMR_STAT_ADDR   2'h3

// ----------------------------------------
// Control and status field positions
// ----------------------------------------
`define TMR_CS_HI   7
`define TMR_CS_LO   6
`define TMR_PS_HI   5
`define TMR_PS_LO   4
`define TMR_SOSC    3
`define TMR_SYNC    2
`define TMR_UNUSED  1
`define TMR_ON      0
`define TMR_ST_FLAG 0
`define TMR_ST_TGL  1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TMR_CTRL_RST  8'h00
`define TMR_CTRL_WMASK 8'hfd
`define TMR_CNT_RST   16'h0000
`define TMR_CNT_MAX   16'hffff
`define TMR_INSTR_DIV 2'h3

`endif

// ===== timer_one_pkg.sv
// Types shared by the timer block
package timer_one_pkg;

  // ----------------------------------------
  // Clock source encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRC_INSTR  = 2'h0,
    SRC_SYSTEM = 2'h1,
    SRC_PIN    = 2'h2,
    SRC_LOWOSC = 2'h3
  } clk_src_t;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // ----------------------------------------
  // Whole state of the block
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic        flag;
    logic        toggle;
    logic [1:0]  div4;
    logic [2:0]  pin_sync;
    logic [2:0]  osc_sync;
    logic [2:0]  gate_sync;
    logic        pin_lvl;
    logic        osc_lvl;
    logic        gate_lvl;
    logic [7:0]  rdata;
  } state_t;

endpackage

// ===== timer_one.sv
// Timer block with control register, prescaler and 16-bit rollover counter
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "timer_one_defines.svh"

module timer_one
  import timer_one_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire reg_req_t    req,
  input  wire logic        clk_pin,
  input  wire logic        low_osc,
  input  wire logic        gate_in,
  output logic [7:0]       rd_data,
  output logic             rollover_flag,
  output logic [15:0]      timer_count,
  output logic             gate_toggle
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Terminal prescale count for a select code
  function automatic logic [2:0] pre_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: pre_last = 3'h0;
      2'h1: pre_last = 3'h1;
      2'h2: pre_last = 3'h3;
      2'h3: pre_last = 3'h7;
    endcase
  endfunction

  // Agreed level of a three-stage synchroniser, older stages only
  function automatic logic sync_level(input logic [2:0] s, input logic old);
    sync_level = (s[1] == s[2]) ? s[2] : old;
  endfunction

  state_t     st_q;
  state_t     st_d;
  logic       run;
  logic       pin_new;
  logic       osc_new;
  logic       gate_new;
  logic       tick;
  logic       adv;
  logic [1:0] ps_sel;
  logic       wr_cnt;
  clk_src_t   src;

  // ----------------------------------------
  // Decode of control fields
  // ----------------------------------------

  // Run enable and field views
  assign run     = st_q.ctrl[`TMR_ON];
  assign ps_sel  = st_q.ctrl[`TMR_PS_HI:`TMR_PS_LO];
  assign src     = clk_src_t'(st_q.ctrl[`TMR_CS_HI:`TMR_CS_LO]);
  assign wr_cnt  = req.wr && (req.addr == `TMR_CNT_LO_ADDR || req.addr == `TMR_CNT_HI_ADDR);
  assign pin_new  = sync_level(st_q.pin_sync, st_q.pin_lvl);
  assign osc_new  = sync_level(st_q.osc_sync, st_q.osc_lvl);
  assign gate_new = sync_level(st_q.gate_sync, st_q.gate_lvl);

  // Input tick from the selected source; pins count on a rising agreed level
  always_comb begin
    unique case (src)
      SRC_INSTR:  tick = (st_q.div4 == `TMR_INSTR_DIV);
      SRC_SYSTEM: tick = 1'b1;
      SRC_PIN:    tick = pin_new && !st_q.pin_lvl;
      SRC_LOWOSC: tick = osc_new && !st_q.osc_lvl;
    endcase
  end

  // prescale terminal count
  // Counter step when the prescaler reaches its last count; a count left above
  // the terminal value by a select change steps at once, so no ticks are swallowed
  // by a wrap through seven
  assign adv = run && tick && (st_q.pre >= pre_last(ps_sel));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;

    // Synchronisers; stage 0 feeds only stage 1
    st_d.pin_sync  = {st_q.pin_sync[1:0], clk_pin};
    st_d.osc_sync  = {st_q.osc_sync[1:0], low_osc};
    st_d.gate_sync = {st_q.gate_sync[1:0], gate_in};
    st_d.pin_lvl   = pin_new;
    st_d.osc_lvl   = osc_new;
    st_d.gate_lvl  = gate_new;

    // Free-running instruction clock divider
    st_d.div4 = st_q.div4 + 2'h1;

    // stop holds the prescaler and gate toggle clear
    if (!run) begin
      st_d.pre    = 3'h0;
      st_d.toggle = 1'b0;
    end else begin
      if (tick) begin
        st_d.pre = (st_q.pre >= pre_last(ps_sel)) ? 3'h0 : st_q.pre + 3'h1;
      end
      if (gate_new && !st_q.gate_lvl) begin
        st_d.toggle = !st_q.toggle;
      end
    end

    // count up and wrap at all ones
    if (adv) begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end

    // Software clears the flag by writing zero; a same-cycle set wins
    if (req.wr && req.addr == `TMR_STAT_ADDR && !req.wdata[`TMR_ST_FLAG]) begin
      st_d.flag = 1'b0;
    end
    if (adv && st_q.cnt == `TMR_CNT_MAX) begin
      st_d.flag = 1'b1;
    end

    // control write; bit 1 is not stored
    if (req.wr && req.addr == `TMR_CTRL_ADDR) begin
      st_d.ctrl = req.wdata & `TMR_CTRL_WMASK;
    end

    // A counter byte write takes precedence over a same-cycle step in that byte only; the other byte keeps the step
    if (req.wr && req.addr == `TMR_CNT_LO_ADDR) begin
      st_d.cnt[7:0] = req.wdata;
    end
    if (req.wr && req.addr == `TMR_CNT_HI_ADDR) begin
      st_d.cnt[15:8] = req.wdata;
    end

    // Read data stands only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `TMR_CTRL_ADDR:   st_d.rdata = st_q.ctrl;
        `TMR_CNT_LO_ADDR: st_d.rdata = st_q.cnt[7:0];
        `TMR_CNT_HI_ADDR: st_d.rdata = st_q.cnt[15:8];
        `TMR_STAT_ADDR:   st_d.rdata = {6'h00, st_q.toggle, st_q.flag};
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ctrl <= `TMR_CTRL_RST;
      st_q.cnt  <= `TMR_CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rd_data       = st_q.rdata;
  assign rollover_flag = st_q.flag;
  assign timer_count   = st_q.cnt;
  assign gate_toggle   = st_q.toggle;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Control write lands in the prescale field one cycle later
  a_prescale_field_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `TMR_CTRL_ADDR) |=> (ps_sel == $past(req.wdata[5:4])))
    else $error("prescale field not written");

  // Divide by eight: no second step within seven cycles while the select holds
  a_div_eight_step: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && ps_sel == 2'h3) |=> (!adv || ps_sel != 2'h3)[*7])
    else $error("divide by eight stepped early");

  // Divide by four: no second step within three cycles while the select holds
  a_div_four_step: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && ps_sel == 2'h2) |=> (!adv || ps_sel != 2'h2)[*3])
    else $error("divide by four stepped early");

  // Divide by two: two system ticks in a row give exactly one step
  a_div_two_step: assert property (@(posedge clk) disable iff (!rst_n)
    (run && ps_sel == 2'h1 && src == SRC_SYSTEM && st_q.pre <= 3'h1)[*2] |->
    (adv != $past(adv)))
    else $error("divide by two miscounted");

  // Divide by two: never two steps back to back
  a_div_two_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && ps_sel == 2'h1) |=> (!adv || ps_sel != 2'h1))
    else $error("divide by two stepped twice");

  // Undivided: each tick while running steps the counter
  a_div_one_step: assert property (@(posedge clk) disable iff (!rst_n)
    (run && tick && ps_sel == 2'h0) |-> adv)
    else $error("undivided tick lost");

  // Unimplemented control bit always reads zero
  a_ctrl_bit_one: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.addr == `TMR_CTRL_ADDR) |=> (rd_data == $past(st_q.ctrl) && !rd_data[1]))
    else $error("control readback wrong");

  // Stopped timer holds its count and clears the toggle
  a_stop_holds_count: assert property (@(posedge clk) disable iff (!rst_n)
    (!run && !wr_cnt) |=> ($stable(st_q.cnt) && !st_q.toggle && st_q.pre == 3'h0))
    else $error("stopped timer moved");

  // Wrap from all ones gives zero and the flag
  a_rollover_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && st_q.cnt == 16'hffff && !wr_cnt) |=> (st_q.cnt == 16'h0000 && rollover_flag))
    else $error("rollover not flagged");

  // Instruction clock source steps at most once per four cycles
  a_instr_src_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && src == SRC_INSTR) |=> (!adv || src != SRC_INSTR)[*3])
    else $error("instruction source stepped early");

  // Pin source counts one rising level once only
  a_pin_tick_once: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && src == SRC_PIN) |=> (!adv || src != SRC_PIN))
    else $error("pin level counted twice");

  // Read data stands only after a read strobe
  a_read_data_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !req.rd |=> (rd_data == 8'h00))
    else $error("read data without strobe");

  // Status read returns toggle and flag
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.addr == `TMR_STAT_ADDR) |=> (rd_data == {6'h00, $past(gate_toggle), $past(rollover_flag)}))
    else $error("status readback wrong");

  // Control write stores every implemented bit
  a_ctrl_write_all: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `TMR_CTRL_ADDR) |=> (st_q.ctrl == ($past(req.wdata) & `TMR_CTRL_WMASK)))
    else $error("control write lost");

  // Control holds without a write
  a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(req.wr && req.addr == `TMR_CTRL_ADDR) |=> $stable(st_q.ctrl))
    else $error("control changed without write");

  // Unimplemented bit is never stored
  a_unused_bit_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !st_q.ctrl[`TMR_UNUSED])
    else $error("unimplemented bit stored");

  // Writing zero clears the flag unless a wrap sets it
  a_flag_clear_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `TMR_STAT_ADDR && !req.wdata[`TMR_ST_FLAG] && !(adv && st_q.cnt == `TMR_CNT_MAX))
    |=> !rollover_flag)
    else $error("flag not cleared");

  // Flag is sticky until software clears it
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (rollover_flag && !(req.wr && req.addr == `TMR_STAT_ADDR && !req.wdata[`TMR_ST_FLAG])) |=> rollover_flag)
    else $error("flag dropped by itself");

  // A step adds exactly one, wrapping at all ones
  a_count_step_one: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && !wr_cnt) |=> (timer_count == $past(timer_count) + 16'h0001))
    else $error("counter step wrong");

  // No step and no write keeps the count
  a_count_holds_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!adv && !wr_cnt) |=> $stable(timer_count))
    else $error("counter moved without step");

  // Low byte write lands over a step
  a_cnt_lo_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `TMR_CNT_LO_ADDR) |=> (timer_count[7:0] == $past(req.wdata)))
    else $error("low byte write lost");

  // High byte write lands over a step
  a_cnt_hi_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.addr == `TMR_CNT_HI_ADDR) |=> (timer_count[15:8] == $past(req.wdata)))
    else $error("high byte write lost");

  // Agreed gate rise flips the toggle while running
  a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n)
    (run && gate_new && !st_q.gate_lvl) |=> (gate_toggle != $past(gate_toggle)))
    else $error("gate toggle missed");

  // Main scenarios
  c_rollover: cover property (@(posedge clk) disable iff (!rst_n)
    adv && st_q.cnt == 16'hffff);
  c_div_eight: cover property (@(posedge clk) disable iff (!rst_n)
    adv && ps_sel == 2'h3);
  c_pin_source: cover property (@(posedge clk) disable iff (!rst_n)
    adv && src == SRC_PIN);
  c_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    run && $rose(st_q.toggle));
  c_flag_clear: cover property (@(posedge clk) disable iff (!rst_n)
    rollover_flag ##1 !rollover_flag);

endmodule

// ===== testbench.sv
// Self-checking testbench for the timer block
`timescale 1ns/10ps
`include "timer_one_defines.svh"

module testbench
  import timer_one_pkg::*;
;
  logic        clk;
  logic        rst_n;
  reg_req_t    req;
  logic        clk_pin;
  logic        low_osc;
  logic        gate_in;
  logic [7:0]  rd_data;
  logic        rollover_flag;
  logic [15:0] timer_count;
  logic        gate_toggle;
  logic [7:0]  got;
  logic [7:0]  first;
  int          errors;
  int          tests_run;

  timer_one dut (
    .clk           (clk),
    .rst_n         (rst_n),
    .req           (req),
    .clk_pin       (clk_pin),
    .low_osc       (low_osc),
    .gate_in       (gate_in),
    .rd_data       (rd_data),
    .rollover_flag (rollover_flag),
    .timer_count   (timer_count),
    .gate_toggle   (gate_toggle)
  );

  // ----------------------------------------
  // Clock and bus tasks
  // ----------------------------------------
  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  // Read data is taken just after the edge that accepts the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    got = rd_data;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Pulse held long enough to pass the input synchroniser
  task automatic pulse(input logic sel);
    @(posedge clk);
    clk_pin <= ~sel;
    low_osc <= sel;
    repeat (4) @(posedge clk);
    clk_pin <= 1'b0;
    low_osc <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  // Tests need about 350 cycles; the 10000-cycle limit means a hang
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    clk_pin = 1'b0;
    low_osc = 1'b0;
    gate_in = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk(got, 8'h00);
    end
    wr(`TMR_CTRL_ADDR, 8'hfe);
    rd(`TMR_CTRL_ADDR);
    chk(got, 8'hfc);
    // steps per window of 8N cycles
    // Divisor grows in the loop so the prescaler never sits above N-1
    for (int p = 0; p < 4; p++) begin
      wr(`TMR_CTRL_ADDR, {2'b01, p[1:0], 4'h1});
      rd(`TMR_CNT_LO_ADDR);
      first = got;
      repeat ((8 << p) - 2) @(posedge clk);
      rd(`TMR_CNT_LO_ADDR);
      chk(got - first, 8'h08);
    end
    // Instruction clock source, undivided: one step per four cycles
    wr(`TMR_CTRL_ADDR, 8'h01);
    rd(`TMR_CNT_LO_ADDR);
    first = got;
    repeat (30) @(posedge clk);
    rd(`TMR_CNT_LO_ADDR);
    chk(got - first, 8'h08);
    wr(`TMR_CTRL_ADDR, 8'h40);
    rd(`TMR_CNT_LO_ADDR);
    first = got;
    repeat (6) @(posedge clk);
    rd(`TMR_CNT_LO_ADDR);
    chk(got, first);
    // Pin and oscillator sources, undivided
    for (int s = 0; s < 2; s++) begin
      wr(`TMR_CNT_LO_ADDR, 8'h00);
      wr(`TMR_CNT_HI_ADDR, 8'h00);
      wr(`TMR_CTRL_ADDR, {1'b1, s[0], 6'h01});
      repeat (5) pulse(s[0]);
      rd(`TMR_CNT_LO_ADDR);
      chk(got, 8'h05);
      wr(`TMR_CTRL_ADDR, 8'h00);
    end
    // gate toggle set while running, cleared by stop
    wr(`TMR_CTRL_ADDR, 8'h41);
    @(posedge clk);
    gate_in <= 1'b1;
    repeat (6) @(posedge clk);
    gate_in <= 1'b0;
    rd(`TMR_STAT_ADDR);
    chk(got, 8'h02);
    wr(`TMR_CTRL_ADDR, 8'h40);
    repeat (2) @(posedge clk);
    chk({7'h00, gate_toggle}, 8'h00);
    wr(`TMR_CNT_LO_ADDR, 8'hff);
    wr(`TMR_CNT_HI_ADDR, 8'hff);
    wr(`TMR_CTRL_ADDR, 8'h41);
    repeat (3) @(posedge clk);
    wr(`TMR_CTRL_ADDR, 8'h40);
    chk({7'h00, rollover_flag}, 8'h01);
    rd(`TMR_CNT_HI_ADDR);
    chk(got, 8'h00);
    chk(timer_count[7:0], 8'h04);
    wr(`TMR_STAT_ADDR, 8'h01);
    rd(`TMR_STAT_ADDR);
    chk(got, 8'h01);
    wr(`TMR_STAT_ADDR, 8'h00);
    rd(`TMR_STAT_ADDR);
    chk(got, 8'h00);
    wrap_up();
  end
endmodule
